// ---- logic/vpd_dispatcher.sv ----
// fetch packet splitter and dispatcher for the vliw core
`timescale 1ns/1ns
`include "vpd_defines.svh"
module vpd_dispatcher
  import vpd_pkg::*;
(
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_b,
  output logic                                      fetchReq,
  input  wire logic                                 fetchValid,
  input  wire logic   [`VPD_FETCH_W-1:0]            fetchData,
  output logic        [`VPD_UNITS-1:0]              unitValid,
  output logic        [`VPD_UNITS-1:0][`VPD_WORD_W-1:0] unitWord,
  output logic                                      unitConflict,
  output logic                                      packetIssued
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  vpd_packet_t buf_q;
  logic        bufValid_q;
  vpd_count_t  ptr_q;
  vpd_packet_t carry_q;
  vpd_count_t  carryCnt_q;

  vpd_packet_t pkt;
  vpd_count_t  takeN;
  vpd_count_t  total;
  logic        ended;

  vpd_issue_if issue ();

  // ----------------------------------------
  // chain scan from the current word
  // ----------------------------------------
  always_comb begin
    int idx;
    int tot;
    int tk;
    int src;
    idx   = 0;
    tot   = int'(carryCnt_q);
    tk    = 0;
    src   = 0;
    ended = 1'b0;
    pkt   = '0;
    for (int i = 0; i < `VPD_WORDS; i++) begin
      idx = int'(ptr_q) + i;
      // stop at the fetch edge; the tail carries into the next packet
      if (!ended && (idx < `VPD_WORDS) && (tot < `VPD_WORDS)) begin
        tk  = tk + 1;
        tot = tot + 1;
        if (!buf_q[idx[2:0]][`VPD_LINK_BIT]) ended = 1'b1;
        else if (tot == `VPD_WORDS) ended = 1'b1;
      end
    end
    // carried head first, then the words of this fetch packet
    for (int k = 0; k < `VPD_WORDS; k++) begin
      src = int'(ptr_q) + k - int'(carryCnt_q);
      if (k < int'(carryCnt_q)) pkt[k] = carry_q[k];
      else if (k < tot) pkt[k] = buf_q[src[2:0]];
    end
    takeN = tk[3:0];
    total = tot[3:0];
  end

  // ----------------------------------------
  // fetch side
  // ----------------------------------------
  // a new line is asked for only once the held one is used up
  assign fetchReq = !bufValid_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      buf_q <= '0;
    end else if (fetchReq && fetchValid) begin
      buf_q <= fetchData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bufValid_q <= 1'b0;
      ptr_q      <= 4'h0;
    end else if (!bufValid_q) begin
      if (fetchValid) begin
        bufValid_q <= 1'b1;
        ptr_q      <= 4'h0;
      end
    end else if (ended) begin
      // one execute packet leaves per cycle until the line is drained
      ptr_q <= ptr_q + takeN;
      if ((ptr_q + takeN) >= 4'(`VPD_WORDS)) bufValid_q <= 1'b0;
    end else begin
      ptr_q      <= 4'(`VPD_WORDS);
      bufValid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // boundary carry
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      carry_q    <= '0;
      carryCnt_q <= 4'h0;
    end else if (bufValid_q) begin
      if (ended) begin
        carryCnt_q <= 4'h0;
      end else begin
        // partial packet is parked, not issued
        carry_q    <= pkt;
        carryCnt_q <= total;
      end
    end
  end

  // ----------------------------------------
  // issue
  // ----------------------------------------
  assign issue.valid = bufValid_q && ended;
  assign issue.count = total;
  assign issue.words = pkt;

  vpd_unit_router u_router (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .issue        (issue.dst),
    .unitValid    (unitValid),
    .unitWord     (unitWord),
    .unitConflict (unitConflict),
    .packetIssued (packetIssued)
  );

endmodule

// ---- logic/vpd_defines.svh ----
// constants for the vliw packet dispatcher
// What this block does
// - instructions are fetched as whole 256-bit fetch packets of eight 32-bit words.
// - a word with its lsb set pulls the following word into the same execute packet.
// - an execute packet holds at most eight chained words, all issued in one cycle.
// - a word with its lsb clear closes the execute packet, so the next word starts a new one.
// - execute packets may run from one fetch packet into the next with no padding.
// - one fetch packet may hold any count of execute packets from one to eight.
// - execute packets go to the functional units at one packet per clock.
// - the next fetch packet is not requested until the current one is fully dispatched or its unfinished tail packet is parked in the carry.
// - the instructions of an execute packet drive their units in the same cycle; of two words on one unit only the later drives it.
// - every multiply goes to one of the two multiply units.
`ifndef VPD_DEFINES_SVH
`define VPD_DEFINES_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define VPD_FETCH_W   256
`define VPD_WORD_W    32
`define VPD_WORDS     8
`define VPD_UNITS     8

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define VPD_LINK_BIT  0
`define VPD_SIDE_BIT  1
`define VPD_CLASS_LSB 2
`define VPD_CLASS_MSB 3

// ----------------------------------------
// unit slots
// ----------------------------------------
`define VPD_SLOT_L_A  3'h0
`define VPD_SLOT_S_A  3'h1
`define VPD_SLOT_M_A  3'h2
`define VPD_SLOT_D_A  3'h3
`define VPD_SLOT_D_B  3'h4
`define VPD_SLOT_M_B  3'h5
`define VPD_SLOT_S_B  3'h6
`define VPD_SLOT_L_B  3'h7

`endif

// ---- logic/vpd_pkg.sv ----
// types shared by the vliw packet dispatcher
package vpd_pkg;
  `include "vpd_defines.svh"

  typedef logic [`VPD_WORD_W-1:0]                 vpd_word_t;
  typedef logic [`VPD_WORDS-1:0][`VPD_WORD_W-1:0] vpd_packet_t;
  typedef logic [3:0]                             vpd_count_t;

  typedef enum logic [1:0] {
    VPD_CLASS_L,
    VPD_CLASS_S,
    VPD_CLASS_M,
    VPD_CLASS_D
  } vpd_class_t;
endpackage

// ---- logic/vpd_issue_if.sv ----
// execute packet hand-off from splitter to unit router
`timescale 1ns/1ns
interface vpd_issue_if;
  import vpd_pkg::*;
  logic        valid;
  vpd_count_t  count;
  vpd_packet_t words;

  modport src (output valid, output count, output words);
  modport dst (input valid, input count, input words);
endinterface

// ---- logic/vpd_unit_router.sv ----
// routes one execute packet onto the eight functional unit slots
`timescale 1ns/1ns
`include "vpd_defines.svh"
module vpd_unit_router
  import vpd_pkg::*;
(
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_b,
  vpd_issue_if.dst                                  issue,
  output logic        [`VPD_UNITS-1:0]              unitValid,
  output logic        [`VPD_UNITS-1:0][`VPD_WORD_W-1:0] unitWord,
  output logic                                      unitConflict,
  output logic                                      packetIssued
);

  // ----------------------------------------
  // slot decode
  // ----------------------------------------
  function automatic logic [2:0] slotOf(input vpd_word_t w);
    vpd_class_t c;
    logic       sideB;
    c     = vpd_class_t'(w[`VPD_CLASS_MSB:`VPD_CLASS_LSB]);
    sideB = w[`VPD_SIDE_BIT];
    unique case (c)
      VPD_CLASS_L: slotOf = sideB ? `VPD_SLOT_L_B : `VPD_SLOT_L_A;
      VPD_CLASS_S: slotOf = sideB ? `VPD_SLOT_S_B : `VPD_SLOT_S_A;
      VPD_CLASS_M: slotOf = sideB ? `VPD_SLOT_M_B : `VPD_SLOT_M_A;
      VPD_CLASS_D: slotOf = sideB ? `VPD_SLOT_D_B : `VPD_SLOT_D_A;
    endcase
  endfunction

  logic [`VPD_UNITS-1:0]                  valid_d;
  logic [`VPD_UNITS-1:0][`VPD_WORD_W-1:0] word_d;
  logic                                   conflict_d;

  always_comb begin
    logic [2:0] s;
    s          = 3'h0;
    valid_d    = '0;
    word_d     = '0;
    conflict_d = 1'b0;
    for (int k = 0; k < `VPD_WORDS; k++) begin
      if (issue.valid && (k < int'(issue.count))) begin
        s = slotOf(issue.words[k]);
        // two words on one unit: flag it, the later word wins the slot
        if (valid_d[s]) conflict_d = 1'b1;
        valid_d[s] = 1'b1;
        word_d[s]  = issue.words[k];
      end
    end
  end

  // ----------------------------------------
  // unit outputs, all slots in one edge
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      unitValid    <= '0;
      unitWord     <= '0;
      unitConflict <= 1'b0;
      packetIssued <= 1'b0;
    end else begin
      unitValid    <= valid_d;
      unitWord     <= word_d;
      unitConflict <= conflict_d;
      packetIssued <= issue.valid;
    end
  end

endmodule

// ---- dv/vpd_fetch_model.sv ----
// program memory model feeding fetch lines to the dispatcher
`timescale 1ns/1ns
module vpd_fetch_model (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         fetchReq,
  output logic              fetchValid,
  output logic [255:0]      fetchData
);
  // ----------------------------------------
  // line server
  // ----------------------------------------
  logic [255:0] lines[$];
  int           gap;
  initial begin
    fetchValid = 1'b0;
    fetchData = '0;
    gap = 0;
  end
  // data inverted while idle so a stale line never passes
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      fetchValid <= 1'b0;
    end else begin
      if (fetchValid && fetchReq) begin
        void'(lines.pop_front());
        gap = $urandom_range(2);
      end else if (gap > 0) begin
        gap--;
      end
      fetchValid <= lines.size() != 0 && gap == 0;
      fetchData <= (lines.size() != 0 && gap == 0) ? lines[0] : ~fetchData;
    end
  end
endmodule

// ---- dv/vpd_dispatcher_sva.sv ----
// port assertions for the packet dispatcher
`timescale 1ns/1ns
module vpd_dispatcher_sva (
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  input wire logic                   fetchReq,
  input wire logic                   fetchValid,
  input wire logic [255:0]           fetchData,
  input wire logic [7:0]             unitValid,
  input wire logic [7:0][31:0]       unitWord,
  input wire logic                   unitConflict,
  input wire logic                   packetIssued
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  function automatic logic [2:0] code(int s);
    return {s < 4 ? 2'(s) : 2'(7 - s), s >= 4};
  endfunction
  issue_mask_a: assert property (packetIssued |-> unitValid != 8'h00)
    else $error("issue with no slot");
  idle_quiet_a: assert property (!packetIssued |-> unitValid == 8'h00)
    else $error("slot active without issue");
  take_issue_a: assert property (fetchReq && fetchValid |-> ##2 packetIssued)
    else $error("line not issued two cycles on");
  held_issue_a: assert property (!fetchReq ##1 !fetchReq |-> packetIssued)
    else $error("gap while line held");
  ready_hold_a: assert property (fetchReq && !fetchValid |=> fetchReq)
    else $error("ready dropped without fetch");
  conflict_pulse_a: assert property (unitConflict |-> packetIssued)
    else $error("conflict outside issue");
  for (genvar i = 0; i < 8; i++) begin : g_slot
    slot_code_a: assert property (unitValid[i] |-> unitWord[i][3:1] == code(i))
      else $error("word on wrong slot");
    zero_word_a: assert property (!unitValid[i] |-> unitWord[i] == 32'h0)
      else $error("idle slot not zero");
  end
  take_c: cover property (fetchReq && fetchValid);
  full_c: cover property (packetIssued && unitValid == 8'hff);
  ready_c: cover property ($rose(fetchReq));
  clash_c: cover property (unitConflict);
endmodule
bind vpd_dispatcher vpd_dispatcher_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b), .fetchReq(fetchReq),
  .fetchValid(fetchValid), .fetchData(fetchData), .unitValid(unitValid), .unitWord(unitWord),
  .unitConflict(unitConflict), .packetIssued(packetIssued));

// ---- dv/tb.sv ----
// self-checking bench for the packet dispatcher
`timescale 1ns/1ns
module tb;
  import vpd_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_b = 1'b0;
  logic         fetchReq, fetchValid, unitConflict, packetIssued;
  logic [255:0] fetchData;
  logic [7:0]   unitValid, cv;
  vpd_packet_t  unitWord, cw;
  logic [264:0] ex[$];
  int           n, fails, checks;
  always #50 clk_sys = ~clk_sys;
  vpd_dispatcher dut (.clk_sys(clk_sys), .rst_b(rst_b), .fetchReq(fetchReq), .fetchValid(fetchValid),
    .fetchData(fetchData), .unitValid(unitValid), .unitWord(unitWord), .unitConflict(unitConflict),
    .packetIssued(packetIssued));
  vpd_fetch_model pm (.clk_sys(clk_sys), .rst_b(rst_b), .fetchReq(fetchReq), .fetchValid(fetchValid),
    .fetchData(fetchData));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [264:0] got, input logic [264:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: packet mismatch", $time);
    end
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // slot index inside a packet picks the unit, so no slot clashes
  task line(input logic [7:0] lk);
    logic [255:0] d;
    logic [31:0]  w;
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      w[3:1] = {n < 4 ? 2'(n) : 2'(7 - n), n >= 4};
      w[0] = lk[k];
      d[32*k +: 32] = w;
      cv[n] = 1'b1;
      cw[n] = w;
      n++;
      if (!lk[k] || n == 8) begin
        ex.push_back({1'b0, cv, cw});
        cv = '0;
        cw = '0;
        n = 0;
      end
    end
    pm.lines.push_back(d);
  endtask
  // two words aimed at one slot: the later word wins and the clash is flagged
  task clash;
    logic [255:0] d;
    logic [31:0]  w;
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      w[3:0] = {3'h0, k == 0};
      d[32*k +: 32] = w;
      if (k > 0) ex.push_back({k == 1, 8'h01, 224'h0, w});
    end
    pm.lines.push_back(d);
  endtask
  // ----------------------------------------
  // monitor and sequence
  // ----------------------------------------
  always @(negedge clk_sys) begin
    if (rst_b && packetIssued === 1'b1) begin
      chk({unitConflict, unitValid, unitWord}, ex.size() ? ex.pop_front() : '1);
    end
  end
  initial begin
    cv = '0;
    cw = '0;
    n = 0;
    fails = 0;
    checks = 0;
    void'($urandom(2781));
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    for (int p = 1; p <= 8; p++) line((8'hff << (p - 1)) & 8'h7f);
    line(8'h80);
    line(8'hff);
    line(8'h00);
    clash();
    repeat (40) line(8'($urandom));
    line(8'h00);
    for (int t = 0; t < 3000 && (ex.size() || pm.lines.size()); t++) @(negedge clk_sys);
    if (ex.size() || pm.lines.size()) begin
      fails++;
      $display("Error at %0t: packets left over", $time);
    end
    wrap_up();
  end
endmodule
